/* File: led_page_pkg.sv */
// constants, field layouts and reset values for the extended page and enhanced indicator block
package led_page_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [4:0] ADDR_PAGE = 5'h1f;
	localparam logic [4:0] ADDR_MODE_SEL = 5'h10;
	localparam logic [4:0] ADDR_BEHAVIOUR = 5'h11;
	localparam logic [4:0] ADDR_SIMPLE_LED = 5'h1b;
	localparam logic [4:0] ADDR_AUX_CTRL = 5'h1c;
	localparam logic [15:0] PAGE_PRIMARY = 16'h0000;
	localparam logic [15:0] PAGE_EXTENDED = 16'h0001;
	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int BEH_PULSE_BIT = 12;
	localparam int BEH_RATE_LSB = 10;
	localparam int BEH_STRETCH_LSB = 5;
	localparam int BEH_METHOD_BIT = 4;
	localparam int AUX_STICKY_BIT = 1;
	localparam int AUX_FDX_BIT = 5;
	localparam int AUX_SPEED_LSB = 3;
	localparam int SIMPLE_PULSE_BIT = 3;
	localparam logic [15:0] BEH_WR_MASK = 16'h1dff;
	localparam logic [15:0] SIMPLE_WR_MASK = 16'hfcce;
	localparam logic [11:0] MODE_RST_LOW = 12'h21a;
	localparam logic [1:0] RATE_RST = 2'h1;
	localparam logic [3:0] STRETCH_RST = 4'hf;
	localparam logic STICKY_EN_RST = 1'b1;
	// ****************************************
	// mode codes and speed encoding
	// ****************************************
	localparam logic [3:0] MODE_DUPLEX_COL = 4'h8;
	localparam logic [3:0] MODE_COLLISION = 4'h9;
	localparam logic [3:0] MODE_ACTIVITY = 4'ha;
	localparam logic [3:0] MODE_FAULT = 4'hc;
	localparam logic [3:0] MODE_FORCE_OFF = 4'he;
	localparam logic [3:0] MODE_FORCE_ON = 4'hf;
	localparam logic [1:0] SPEED_10 = 2'h0;
	localparam logic [1:0] SPEED_100 = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_FREQ_MHZ = 10;
	localparam int TICK_US = 25000;
	localparam int TICK_CYCLES = TICK_US * CLK_FREQ_MHZ;
	localparam logic [4:0] STRETCH_TICKS_SLOW = 5'h10;
	localparam logic [4:0] BLINK_HALF_TICKS_SLOW = 5'h08;
	localparam int PULSE_PERIOD_US = 200;
	localparam int PULSE_ON_US = 40;
	localparam int PULSE_CNT_W = 11;
	localparam logic [PULSE_CNT_W-1:0] PULSE_PERIOD_CYCLES = PULSE_CNT_W'(PULSE_PERIOD_US * CLK_FREQ_MHZ);
	localparam logic [PULSE_CNT_W-1:0] PULSE_ON_CYCLES = PULSE_CNT_W'(PULSE_ON_US * CLK_FREQ_MHZ);
endpackage

/* File: ext_page_led_control.sv */
// extended page decode, page-select register and enhanced indicator controller
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
module ext_page_led_control
	import led_page_pkg::*;
#(
	parameter int P_TICK_CYCLES = TICK_CYCLES
) (
	// clock and resets
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_soft_rst,
	// straps: [7:4] output 3 mode, [3:0] combine disable
	input wire logic [7:0] i_config_strap_inputs,
	// register port
	input wire logic [4:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// link status sources
	input wire logic i_link_up,
	input wire logic [1:0] i_speed,
	input wire logic i_full_duplex,
	input wire logic i_activity,
	input wire logic i_collision,
	input wire logic i_autoneg_fault,
	// indicator pins, high = lit
	output logic o_indicator_out_0,
	output logic o_indicator_out_1,
	output logic o_indicator_out_2,
	output logic o_indicator_out_3
);

	// ****************************************
	// functions
	// ****************************************
	// ticks scale down by a power of two per rate step
	function automatic logic [4:0] rate_ticks(input logic [4:0] slow, input logic [1:0] rate);
		rate_ticks = slow >> rate;
	endfunction

	function automatic logic speed_match(input logic [3:0] mode, input logic [1:0] spd);
		logic s10;
		logic s100;
		logic s1000;
		s10 = (spd == SPEED_10);
		s100 = (spd == SPEED_100);
		s1000 = (spd == SPEED_1000);
		case (mode)
			4'h0: speed_match = 1'b1;
			4'h1: speed_match = s1000;
			4'h2: speed_match = s100;
			4'h3: speed_match = s10;
			4'h4: speed_match = s100 | s1000;
			4'h5: speed_match = s10 | s1000;
			4'h6: speed_match = s10 | s100;
			default: speed_match = 1'b0;
		endcase
	endfunction

	function automatic logic led_level(input logic [3:0] mode, input logic comb_dis, input logic act_show,
			input logic col_show, input logic link, input logic [1:0] spd, input logic fdx, input logic fault);
		logic lnk;
		lnk = link & speed_match(mode, spd);
		if (mode <= 4'h6) begin
			led_level = comb_dis ? lnk : (lnk & ~act_show);
		end else begin
			case (mode)
				MODE_DUPLEX_COL: led_level = comb_dis ? fdx : (fdx | col_show);
				MODE_COLLISION: led_level = col_show;
				MODE_ACTIVITY: led_level = act_show;
				MODE_FAULT: led_level = fault;
				MODE_FORCE_OFF: led_level = 1'b0;
				MODE_FORCE_ON: led_level = 1'b1;
				default: led_level = 1'b0;
			endcase
		end
	endfunction

	// ****************************************
	// registers
	// ****************************************
	logic [15:0] page_r;
	logic [15:0] mode_r;
	logic [15:0] mode_nxt;
	logic [15:0] beh_r;
	logic [15:0] beh_nxt;
	logic [15:0] simple_r;
	logic [15:0] simple_nxt;
	logic sticky_en_r;
	logic [7:0] strap_r;
	logic rst_d_r;
	logic [15:0] rdata_r;
	logic [3:0] led_r;

	// ****************************************
	// address decode
	// ****************************************
	wire ext_sel = (page_r == PAGE_EXTENDED);
	wire upper_addr = (i_addr >= 5'h10) && (i_addr <= 5'h1e);
	wire hit_page = (i_addr == ADDR_PAGE);
	// extended page owns 16-30 while selected
	wire hit_mode = ext_sel && (i_addr == ADDR_MODE_SEL);
	wire hit_beh = ext_sel && (i_addr == ADDR_BEHAVIOUR);
	wire hit_simple = !ext_sel && (i_addr == ADDR_SIMPLE_LED);
	wire hit_aux = !ext_sel && (i_addr == ADDR_AUX_CTRL);
	wire low_addr = !upper_addr && !hit_page;

	// ****************************************
	// strap capture and software reset defaults
	// ****************************************
	// strap load on release
	wire strap_load = rst_d_r && !i_sys_rst;
	wire [7:0] strap_src = strap_load ? i_config_strap_inputs : strap_r;
	// sticky fields revert only when enable clear
	wire load_defaults = strap_load || (i_soft_rst && !sticky_en_r);
	wire [15:0] mode_def = {strap_src[7:4], MODE_RST_LOW};
	wire [15:0] beh_def = {3'h0, 1'b0, RATE_RST, 1'b0, STRETCH_RST, 1'b0, strap_src[3:0]};

	always_comb begin
		mode_nxt = mode_r;
		beh_nxt = beh_r;
		simple_nxt = simple_r;
		if (load_defaults) begin
			mode_nxt = mode_def;
			beh_nxt = beh_def;
			simple_nxt = 16'h0000;
		end else if (i_wr) begin
			if (hit_mode) begin
				mode_nxt = i_wdata;
			end
			if (hit_beh) begin
				beh_nxt = i_wdata & BEH_WR_MASK;
			end
			if (hit_simple) begin
				simple_nxt = i_wdata & SIMPLE_WR_MASK;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rst_d_r <= 1'b1;
			strap_r <= 8'h00;
		end else begin
			rst_d_r <= 1'b0;
			if (strap_load) begin
				strap_r <= i_config_strap_inputs;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			mode_r <= {4'h0, MODE_RST_LOW};
			beh_r <= {3'h0, 1'b0, RATE_RST, 1'b0, STRETCH_RST, 1'b0, 4'h0};
			simple_r <= 16'h0000;
		end else begin
			mode_r <= mode_nxt;
			beh_r <= beh_nxt;
			simple_r <= simple_nxt;
		end
	end

	// page and sticky enable survive a software reset
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			page_r <= PAGE_PRIMARY;
			sticky_en_r <= STICKY_EN_RST;
		end else if (i_wr) begin
			if (hit_page) begin
				page_r <= i_wdata;
			end
			if (hit_aux) begin
				sticky_en_r <= i_wdata[AUX_STICKY_BIT];
			end
		end
	end

	// ****************************************
	// read path
	// ****************************************
	wire [15:0] aux_rd = 16'(({15'h0, sticky_en_r} << AUX_STICKY_BIT)
		| ({15'h0, i_full_duplex} << AUX_FDX_BIT) | ({14'h0, i_speed} << AUX_SPEED_LSB));
	wire [15:0] rd_mux = hit_page ? page_r :
		hit_mode ? mode_r :
		hit_beh ? beh_r :
		hit_simple ? simple_r :
		hit_aux ? aux_rd : 16'h0000;

	// data only in the cycle after the strobe; lower block and unheld addresses read zero
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= (i_rd && !low_addr) ? rd_mux : 16'h0000;
		end
	end
	assign o_rdata = rdata_r;

	// ****************************************
	// timebase
	// ****************************************
	logic [31:0] tick_cnt_r;
	logic [PULSE_CNT_W-1:0] pulse_cnt_r;
	wire tick = (tick_cnt_r == 32'(P_TICK_CYCLES - 1));

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst || tick) begin
			tick_cnt_r <= 32'h0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
		end
	end

	// 5 kHz carrier at 20% duty
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst || (pulse_cnt_r == PULSE_PERIOD_CYCLES - PULSE_CNT_W'(1))) begin
			pulse_cnt_r <= '0;
		end else begin
			pulse_cnt_r <= pulse_cnt_r + PULSE_CNT_W'(1);
		end
	end
	wire pulse_on = (pulse_cnt_r < PULSE_ON_CYCLES);

	// ****************************************
	// stretch and blink
	// ****************************************
	wire [1:0] rate = beh_r[BEH_RATE_LSB +: 2];
	wire [4:0] stretch_len = rate_ticks(STRETCH_TICKS_SLOW, rate);
	wire [4:0] blink_half = rate_ticks(BLINK_HALF_TICKS_SLOW, rate);
	logic [4:0] act_cnt_r;
	logic [4:0] col_cnt_r;
	logic [4:0] blink_cnt_r;
	logic blink_phase_r;

	// stretch ends up to one tick early, as the first tick is not aligned to the event
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			act_cnt_r <= 5'h0;
			col_cnt_r <= 5'h0;
		end else begin
			if (i_activity) begin
				act_cnt_r <= stretch_len;
			end else if (tick && act_cnt_r != 5'h0) begin
				act_cnt_r <= act_cnt_r - 5'h1;
			end
			if (i_collision) begin
				col_cnt_r <= stretch_len;
			end else if (tick && col_cnt_r != 5'h0) begin
				col_cnt_r <= col_cnt_r - 5'h1;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			blink_cnt_r <= 5'h0;
			blink_phase_r <= 1'b0;
		end else if (tick) begin
			if (blink_cnt_r >= blink_half - 5'h1) begin
				blink_cnt_r <= 5'h0;
				blink_phase_r <= !blink_phase_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 5'h1;
			end
		end
	end

	wire act_str = (act_cnt_r != 5'h0);
	wire col_str = (col_cnt_r != 5'h0);

	// ****************************************
	// indicator selection
	// ****************************************
	logic [3:0] enh_on;
	logic [3:0] simple_on;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_led
			wire sel_stretch = beh_r[BEH_STRETCH_LSB + g];
			wire act_show = sel_stretch ? act_str : (act_str & blink_phase_r);
			wire col_show = sel_stretch ? col_str : (col_str & blink_phase_r);
			assign enh_on[g] = led_level(mode_r[4*g +: 4], beh_r[g], act_show, col_show,
				i_link_up, i_speed, i_full_duplex, i_autoneg_fault);
		end
	endgenerate

	// simple method: fixed sources with force-on and disable pairs
	wire [3:0] simple_src = {i_link_up && i_speed == SPEED_10, i_link_up && i_speed == SPEED_100,
		i_link_up && i_speed == SPEED_1000, act_str};
	wire [3:0] simple_force = {simple_r[15], simple_r[13], simple_r[11], simple_r[7]};
	wire [3:0] simple_dis = {simple_r[14], simple_r[12], simple_r[10], simple_r[6]};
	assign simple_on = simple_force | (simple_src & ~simple_dis);

	wire method_enh = beh_r[BEH_METHOD_BIT];
	wire [3:0] sel_on = method_enh ? enh_on : simple_on;
	wire pulse_en = method_enh ? beh_r[BEH_PULSE_BIT] : simple_r[SIMPLE_PULSE_BIT];
	wire [3:0] led_nxt = sel_on & {4{!pulse_en || pulse_on}};

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			led_r <= 4'h0;
		end else begin
			led_r <= led_nxt;
		end
	end

	assign o_indicator_out_0 = led_r[0];
	assign o_indicator_out_1 = led_r[1];
	assign o_indicator_out_2 = led_r[2];
	assign o_indicator_out_3 = led_r[3];

endmodule // ext_page_led_control

/* File: mgmt_model.sv */
// register-port master model for the management side
`timescale 1ns/1ns
module mgmt_model (
	// bus to the device
	input wire logic i_clk,
	input wire logic [15:0] i_rdata,
	output logic [4:0] o_addr,
	output logic [15:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	initial begin
		o_addr = 5'h00;
		o_wdata = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		// stale values are inverted so nothing leans on them
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(negedge i_clk);
		d = i_rdata;
	endtask
endmodule // mgmt_model

/* File: led_chk_assertions.sv */
// checker for page decode, read data and indicator outputs
`timescale 1ns/1ns
module led_chk
	import led_page_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_soft_rst,
	input wire logic [7:0] i_config_strap_inputs,
	input wire logic [4:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic o_indicator_out_0,
	input wire logic o_indicator_out_3
);
	logic [15:0] pg_r, md_r, bh_r;
	logic [7:0] sp_r;
	logic st_r, first_r;
	logic [10:0] hi_r;
	wire ext = pg_r == PAGE_EXTENDED;
	// ****
	// shadow of the register state
	// ****
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			pg_r <= 16'h0000;
			st_r <= 1'b1;
			first_r <= 1'b1;
			md_r <= 16'h0000;
			bh_r <= 16'h0000;
		end else begin
			first_r <= 1'b0;
			if (i_wr && i_addr == ADDR_PAGE)
				pg_r <= i_wdata;
			if (i_wr && !ext && i_addr == ADDR_AUX_CTRL)
				st_r <= i_wdata[AUX_STICKY_BIT];
			if (first_r) begin
				sp_r <= i_config_strap_inputs;
				md_r <= {i_config_strap_inputs[7:4], MODE_RST_LOW};
				bh_r <= 16'h05e0 | {12'h000, i_config_strap_inputs[3:0]};
			end else if (i_soft_rst && !st_r) begin
				md_r <= {sp_r[7:4], MODE_RST_LOW};
				bh_r <= 16'h05e0 | {12'h000, sp_r[3:0]};
			end else if (i_wr && ext && i_addr == ADDR_MODE_SEL)
				md_r <= i_wdata;
			else if (i_wr && ext && i_addr == ADDR_BEHAVIOUR)
				bh_r <= i_wdata & BEH_WR_MASK;
		end
	end
	// cleared while pulsing is off so a steady light never counts
	always_ff @(posedge i_sys_clk)
		hi_r <= (o_indicator_out_3 && bh_r[BEH_PULSE_BIT]) ? hi_r + 11'h001 : 11'h000;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	// ****
	// properties
	// ****
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data not idle");
	a_low_addr: assert property (i_rd && i_addr < 5'h10 |=> o_rdata == 16'h0000) else $error("low address");
	a_page_read: assert property (i_rd && i_addr == ADDR_PAGE |=> o_rdata == $past(pg_r)) else $error("page value");
	a_ext_hides: assert property (i_rd && ext && i_addr == ADDR_AUX_CTRL |=> o_rdata == 16'h0000) else $error("aux seen");
	a_primary_back: assert property (i_rd && !ext && i_addr == ADDR_MODE_SEL |=> o_rdata == 16'h0000) else $error("ext seen");
	a_mode_read: assert property (i_rd && ext && i_addr == ADDR_MODE_SEL |=> o_rdata == $past(md_r)) else $error("mode value");
	a_beh_read: assert property (i_rd && ext && i_addr == ADDR_BEHAVIOUR |=> o_rdata == $past(bh_r)) else $error("behaviour");
	a_force_on: assert property (bh_r[4] && !bh_r[12] && md_r[3:0] == MODE_FORCE_ON |=> o_indicator_out_0) else $error("not on");
	a_force_off: assert property (bh_r[4] && md_r[15:12] == MODE_FORCE_OFF |=> !o_indicator_out_3) else $error("not off");
	a_pulse_on: assert property (bh_r[4] && bh_r[12] |-> hi_r <= 11'h192) else $error("pulse too long");
	c_page: cover property (i_wr && i_addr == ADDR_PAGE && i_wdata == PAGE_EXTENDED);
	c_pulse: cover property (bh_r[12] && o_indicator_out_3);
	c_soft: cover property (i_soft_rst && !st_r);
endmodule // led_chk
bind ext_page_led_control led_chk i_led_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_soft_rst(i_soft_rst),
	.i_config_strap_inputs(i_config_strap_inputs), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .o_indicator_out_0(o_indicator_out_0), .o_indicator_out_3(o_indicator_out_3));

/* File: ext_page_led_control_tb.sv */
// testbench for the extended page decode and indicator controller
`timescale 1ns/1ns
module ext_page_led_control_tb;
	import led_page_pkg::*;
	logic clk, rst, srst, wr, rd, link, fdx, act, col, flt, o0, o1, o2, o3;
	logic [7:0] strap;
	logic [4:0] addr;
	logic [15:0] wdata, rdata;
	logic [1:0] spd;
	int fails, check_count, h;
	wire [3:0] leds = {o3, o2, o1, o0};
	// bit c set where mode c lights at link 1000, full duplex, fault, no traffic
	localparam logic [15:0] EXP_M = 16'h9133;
	ext_page_led_control #(.P_TICK_CYCLES(4)) i_ext_page_led_control (.i_sys_clk(clk), .i_sys_rst(rst),
		.i_soft_rst(srst), .i_config_strap_inputs(strap), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_link_up(link), .i_speed(spd), .i_full_duplex(fdx), .i_activity(act),
		.i_collision(col), .i_autoneg_fault(flt), .o_indicator_out_0(o0), .o_indicator_out_1(o1),
		.o_indicator_out_2(o2), .o_indicator_out_3(o3));
	mgmt_model i_mgmt_model (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [4:0] a, input logic [15:0] e);
		logic [15:0] d;
		i_mgmt_model.rd(a, d);
		chk(d, e);
	endtask
	task automatic w(input logic [4:0] a, input logic [15:0] d);
		i_mgmt_model.wr(a, d);
		repeat (3) @(negedge clk);
	endtask
	task automatic hc(input int n, input int k);
		h = 0;
		repeat (n) begin
			@(negedge clk);
			// only a firm high counts, so an unknown level never passes
			h += (leds[k] === 1'b1) ? 1 : 0;
		end
	endtask
	task automatic pulse_soft;
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		fails++;
		conclude;
	end
	initial begin
		{rst, srst, act, col, link, fdx, flt} = 7'b1000111;
		strap = 8'h5b;
		spd = SPEED_1000;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rc(ADDR_PAGE, 16'h0000);
		rc(ADDR_AUX_CTRL, 16'h0032);
		rc(5'h05, 16'h0000);
		w(ADDR_PAGE, PAGE_EXTENDED);
		rc(ADDR_PAGE, 16'h0001);
		rc(ADDR_MODE_SEL, 16'h521a);
		rc(ADDR_BEHAVIOUR, 16'h05eb);
		rc(ADDR_AUX_CTRL, 16'h0000);
		rc(5'h05, 16'h0000);
		w(ADDR_BEHAVIOUR, 16'hffff);
		rc(ADDR_BEHAVIOUR, 16'h1dff);
		$display("registers done");
		w(ADDR_BEHAVIOUR, 16'h05f0);
		for (int c = 0; c < 16; c++) begin
			w(ADDR_MODE_SEL, {4{c[3:0]}});
			chk({12'h000, leds}, {12'h000, {4{EXP_M[c]}}});
		end
		w(ADDR_MODE_SEL, 16'h9999);
		@(posedge clk);
		col <= 1'b1;
		@(posedge clk);
		col <= 1'b0;
		repeat (2) @(negedge clk);
		chk({12'h000, leds}, 16'h000f);
		@(posedge clk);
		flt <= 1'b0;
		w(ADDR_MODE_SEL, 16'hcccc);
		chk({12'h000, leds}, 16'h0000);
		@(posedge clk);
		flt <= 1'b1;
		$display("modes done");
		w(ADDR_MODE_SEL, 16'haaaa);
		for (int r = 0; r < 4; r++) begin
			w(ADDR_BEHAVIOUR, {4'h0, 2'(r), 10'h1f0});
			@(posedge clk);
			act <= 1'b1;
			@(posedge clk);
			act <= 1'b0;
			hc(80, 0);
			chk({15'h0000, h inside {[((16 >> r) - 1) * 4:(16 >> r) * 4 + 2]}}, 16'h0001);
		end
		w(ADDR_BEHAVIOUR, 16'h0c10);
		@(posedge clk);
		act <= 1'b1;
		hc(40, 0);
		chk({15'h0000, h inside {[14:26]}}, 16'h0001);
		w(ADDR_MODE_SEL, 16'h0000);
		w(ADDR_BEHAVIOUR, 16'h05f0);
		chk({15'h0000, o0}, 16'h0000);
		w(ADDR_BEHAVIOUR, 16'h05f1);
		chk({15'h0000, o0}, 16'h0001);
		@(posedge clk);
		act <= 1'b0;
		$display("activity done");
		w(ADDR_MODE_SEL, 16'hffff);
		w(ADDR_BEHAVIOUR, 16'h15f0);
		hc(4000, 3);
		chk({15'h0000, h inside {[799:801]}}, 16'h0001);
		w(ADDR_BEHAVIOUR, 16'h05e0);
		chk({15'h0000, o2}, 16'h0000);
		w(ADDR_PAGE, PAGE_PRIMARY);
		rc(ADDR_MODE_SEL, 16'h0000);
		w(ADDR_SIMPLE_LED, 16'h2000);
		chk({15'h0000, o2}, 16'h0001);
		w(ADDR_PAGE, PAGE_EXTENDED);
		w(ADDR_MODE_SEL, 16'h0e00);
		w(ADDR_BEHAVIOUR, 16'h05f0);
		chk({15'h0000, o2}, 16'h0000);
		$display("method done");
		w(ADDR_MODE_SEL, 16'h1234);
		pulse_soft();
		rc(ADDR_MODE_SEL, 16'h1234);
		w(ADDR_PAGE, PAGE_PRIMARY);
		w(ADDR_AUX_CTRL, 16'h0000);
		w(ADDR_PAGE, PAGE_EXTENDED);
		pulse_soft();
		rc(ADDR_MODE_SEL, 16'h521a);
		rc(ADDR_BEHAVIOUR, 16'h05eb);
		rc(ADDR_PAGE, 16'h0001);
		$display("soft reset done");
		conclude;
	end
endmodule // ext_page_led_control_tb
